// ===== logic/fp_nan_exception_policy.v
`include "fp_nan_regs.vh"
module fp_nan_exception_policy (
   input  wire         clk_sys,
   input  wire         reset,
   input  wire         clkEn,
   // operation request from the pipeline
   input  wire         opValid,
   input  wire [2:0]   opKind,
   input  wire [1:0]   srcFmt,
   input  wire [1:0]   dstFmt,
   input  wire [4:0]   rs1Num,
   input  wire [4:0]   rs2Num,
   input  wire [4:0]   rdNum,
   input  wire [127:0] rs1Val,
   input  wire [127:0] rs2Val,
   input  wire         rs1Used,
   input  wire [1:0]   cmpOrder,
   input  wire         arithInvalid,
   input  wire [4:0]   arithExc,
   input  wire [127:0] arithResult,
   input  wire [2:0]   queueCount,
   input  wire         userHandlerEntry,
   // result write-back
   output reg          resultValid,
   output reg  [127:0] resultData,
   output reg  [4:0]   resultReg,
   output reg          fccValid,
   // trap interface to the integer unit
   output reg          floatTrap,
   output reg  [2:0]   trapType,
   output reg  [4:0]   trapCause,
   // apb
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output wire         pready,
   output wire         pslverr,
   output wire         irq
);
   reg  [1:0]   fccQ;
   reg  [4:0]   cexcQ;
   reg  [4:0]   aexcQ;
   reg  [2:0]   fttQ;
   reg  [4:0]   trapMaskQ;
   reg  [2:0]   irqStatQ;
   reg  [2:0]   irqMaskQ;

   // operand classification and quieted copies
   wire         rs1Nan;
   wire         rs1Snan;
   wire         rs2Nan;
   wire         rs2Snan;
   wire [127:0] conv2;
   wire [127:0] quiet1;
   wire [127:0] quiet2;

   // per-operation decisions
   reg          misalign;
   reg          seqErr;
   reg          invalid;
   reg  [127:0] resD;
   reg  [1:0]   fccD;
   reg          writesRes;
   reg          writesFcc;
   reg  [4:0]   excD;
   reg          ieeeTrap;
   reg  [4:0]   trapBit;
   reg  [2:0]   trapCodeD;

   // bus decode and read path
   wire         apbWrite;
   wire         apbRead;
   wire         apbSetup;
   wire [31:0]  statusWord;
   reg  [31:0]  readMux;

   // register alignment check shared by all three register fields
   function badAlign;
      input [4:0] num;
      input [1:0] fmt;
      begin
         case (fmt)
            `FMT_D: badAlign = num[0];
            `FMT_Q: badAlign = |num[1:0];
            default: badAlign = 1'b0;
         endcase
      end
   endfunction

   // pick lowest set exception bit, keeping exactly one cause
   function [4:0] oneHot;
      input [4:0] v;
      begin
         oneHot = v & (~v + 5'h01);
      end
   endfunction

   // trap type priority: register alignment, then queue sequence, then arithmetic
   function [2:0] trapCode;
      input misal;
      input seq;
      begin
         if (misal)
            trapCode = `FTT_BADREG;
         else if (seq)
            trapCode = `FTT_SEQ;
         else
            trapCode = `FTT_IEEE;
      end
   endfunction

   nan_classify uClass1 (
      .opnd   (rs1Val),
      .fmt    (srcFmt),
      .isNan  (rs1Nan),
      .isSnan (rs1Snan)
   );
   nan_classify uClass2 (
      .opnd   (rs2Val),
      .fmt    (srcFmt),
      .isNan  (rs2Nan),
      .isSnan (rs2Snan)
   );
   nan_transform uConv (
      .opnd   (rs2Val),
      .srcFmt (srcFmt),
      .dstFmt (dstFmt),
      .result (conv2)
   );
   nan_transform uQuiet1 (
      .opnd   (rs1Val),
      .srcFmt (srcFmt),
      .dstFmt (srcFmt),
      .result (quiet1)
   );
   nan_transform uQuiet2 (
      .opnd   (rs2Val),
      .srcFmt (srcFmt),
      .dstFmt (srcFmt),
      .result (quiet2)
   );

   // decide result, condition code and exceptions for one operation
   always @* begin
      misalign = 1'b0;
      seqErr = 1'b0;
      invalid = 1'b0;
      resD = arithResult;
      fccD = cmpOrder;
      writesRes = 1'b0;
      writesFcc = 1'b0;
      excD = 5'h00;
      if (opKind != `OP_QREAD)
         misalign = badAlign(rs2Num, srcFmt) || (rs1Used && badAlign(rs1Num, srcFmt))
                    || badAlign(rdNum, (opKind == `OP_CONV) ? dstFmt : srcFmt);
      case (opKind)
         `OP_QREAD: seqErr = (queueCount == 3'h0);
         `OP_CONV: begin
            writesRes = 1'b1;
            if (rs2Nan) begin
               resD = conv2;
               invalid = rs2Snan;
            end
         end
         `OP_CMP: begin
            writesFcc = 1'b1;
            if ((rs1Nan && rs1Used) || rs2Nan)
               fccD = `FCC_UN;
            invalid = (rs1Snan && rs1Used) || rs2Snan;
         end
         `OP_CMPE: begin
            writesFcc = 1'b1;
            if ((rs1Nan && rs1Used) || rs2Nan) begin
               fccD = `FCC_UN;
               invalid = 1'b1;
            end
         end
         `OP_ARITH1: begin
            writesRes = 1'b1;
            if (rs2Nan) begin
               resD = rs2Snan ? quiet2 : rs2Val;
               invalid = rs2Snan;
            end else if (arithInvalid) begin
               invalid = 1'b1;
               resD = {1'b0, {127{1'b1}}};
            end
         end
         `OP_ARITH2: begin
            writesRes = 1'b1;
            if (rs2Snan) begin
               resD = quiet2;
               invalid = 1'b1;
            end else if (rs1Snan) begin
               resD = quiet1;
               invalid = 1'b1;
            end else if (rs2Nan) begin
               resD = rs2Val;
            end else if (rs1Nan) begin
               resD = rs1Val;
            end else if (arithInvalid) begin
               invalid = 1'b1;
               resD = {1'b0, {127{1'b1}}};
            end
         end
         default: writesRes = 1'b0;
      endcase
      excD = (invalid ? (5'h01 << `NV_BIT) : 5'h00)
             | ((opKind == `OP_ARITH1 || opKind == `OP_ARITH2) ? arithExc : 5'h00);
      trapCodeD = trapCode(misalign, seqErr);
      trapBit = oneHot(excD & trapMaskQ);
      ieeeTrap = |(excD & trapMaskQ);
   end

   // commit state or raise a trap at the end of each operation
   always @(posedge clk_sys) begin
      if (reset) begin
         fccQ <= `FCC_EQ;
         cexcQ <= 5'h00;
         aexcQ <= 5'h00;
         fttQ <= `FTT_NONE;
         resultValid <= 1'b0;
         resultData <= 128'h0;
         resultReg <= 5'h00;
         fccValid <= 1'b0;
         floatTrap <= 1'b0;
         trapType <= `FTT_NONE;
         trapCause <= 5'h00;
      end else if (clkEn) begin
         resultValid <= 1'b0;
         fccValid <= 1'b0;
         floatTrap <= 1'b0;
         if (userHandlerEntry)
            fttQ <= `FTT_NONE;
         if (opValid) begin
            if (misalign || seqErr || ieeeTrap) begin
               // destination, fcc and aexc untouched
               floatTrap <= 1'b1;
               trapType <= trapCodeD;
               fttQ <= trapCodeD;
               trapCause <= (misalign || seqErr) ? 5'h00 : trapBit;
               if (!misalign && !seqErr)
                  cexcQ <= trapBit;
            end else begin
               resultValid <= writesRes;
               resultData <= resD;
               resultReg <= rdNum;
               fccValid <= writesFcc;
               if (writesFcc)
                  fccQ <= fccD;
               cexcQ <= excD;
               aexcQ <= aexcQ | excD;
               fttQ <= `FTT_NONE;
            end
         end
      end
   end

   assign apbWrite = psel && penable && pwrite;
   assign apbRead = psel && penable && !pwrite;
   assign apbSetup = psel && !penable;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq = |(irqStatQ & irqMaskQ);

   // masks, sticky events (trap, sequence error, misalignment), read clears status
   always @(posedge clk_sys) begin
      if (reset) begin
         trapMaskQ <= `RST_TRAPMASK;
         irqMaskQ <= `RST_IRQMASK;
         irqStatQ <= 3'h0;
      end else if (clkEn) begin
         if (apbWrite && paddr == `OFS_TRAPMASK)
            trapMaskQ <= pwdata[4:0];
         if (apbWrite && paddr == `OFS_IRQMASK)
            irqMaskQ <= pwdata[2:0];
         // clear only the bits reported in the setup phase, so an event between phases is kept
         irqStatQ <= ((apbRead && paddr == `OFS_IRQSTAT) ? (irqStatQ & ~prdata[2:0]) : irqStatQ)
                     | {opValid && misalign, opValid && seqErr, opValid && ieeeTrap && !misalign && !seqErr};
      end
   end

   // status word: cexc, aexc, fcc, a reserved zero, qne, ftt; qne reads zero once ftt clears
   assign statusWord = {15'h0, fttQ, (queueCount != 3'h0) && (fttQ != `FTT_NONE), 1'b0,
                        fccQ, aexcQ, cexcQ};

   // read mux over the register offsets; unmapped offsets read zero
   always @* begin
      case (paddr)
         `OFS_STATUS: readMux = statusWord;
         `OFS_IRQSTAT: readMux = {29'h0, irqStatQ};
         `OFS_IRQMASK: readMux = {29'h0, irqMaskQ};
         `OFS_TRAPMASK: readMux = {27'h0, trapMaskQ};
         `OFS_QCOUNT: readMux = {29'h0, queueCount};
         default: readMux = 32'h0;
      endcase
   end

   // read data are captured in the setup phase and stand through the access phase
   always @(posedge clk_sys) begin
      if (reset)
         prdata <= 32'h0;
      else if (clkEn && apbSetup)
         prdata <= readMux;
   end
endmodule // fp_nan_exception_policy

// ===== logic/fp_nan_regs.vh
`ifndef FP_NAN_REGS_VH
`define FP_NAN_REGS_VH
// apb offsets
`define OFS_STATUS      12'h000
`define OFS_IRQSTAT     12'h004
`define OFS_IRQMASK     12'h008
`define OFS_TRAPMASK    12'h00C
`define OFS_QCOUNT      12'h010
// status word fields
`define FCC_LSB         10
`define FTT_LSB         14
`define QNE_BIT         13
`define CEXC_LSB        0
`define AEXC_LSB        5
// trap type codes
`define FTT_NONE        3'h0
`define FTT_IEEE        3'h1
`define FTT_SEQ         3'h4
`define FTT_BADREG      3'h6
// condition codes
`define FCC_EQ          2'h0
`define FCC_LT          2'h1
`define FCC_GT          2'h2
`define FCC_UN          2'h3
// operations
`define OP_NONE         3'h0
`define OP_CONV         3'h1
`define OP_CMP          3'h2
`define OP_CMPE         3'h3
`define OP_ARITH1       3'h4
`define OP_ARITH2       3'h5
`define OP_QREAD        3'h6
// formats
`define FMT_S           2'h0
`define FMT_D           2'h1
`define FMT_Q           2'h2
// reset values, and the invalid-operation exception bit position
`define RST_TRAPMASK    5'h00
`define RST_IRQMASK     3'h0
`define NV_BIT          4
`endif

// ===== logic/nan_classify.v
`include "fp_nan_regs.vh"
// classify a left-aligned 128-bit operand of a given format
module nan_classify (
   input  wire [127:0] opnd,
   input  wire [1:0]   fmt,
   output reg          isNan,
   output reg          isSnan
);
   // exponent all ones, fraction nonzero; quiet bit is the fraction msb
   always @* begin
      isNan = 1'b0;
      isSnan = 1'b0;
      case (fmt)
         `FMT_S: begin
            isNan = (&opnd[126:119]) && (|opnd[118:96]);
            isSnan = isNan && !opnd[118];
         end
         `FMT_D: begin
            isNan = (&opnd[126:116]) && (|opnd[115:64]);
            isSnan = isNan && !opnd[115];
         end
         default: begin
            isNan = (&opnd[126:112]) && (|opnd[111:0]);
            isSnan = isNan && !opnd[111];
         end
      endcase
   end
endmodule // nan_classify

// ===== logic/nan_transform.v
`include "fp_nan_regs.vh"
// re-pack a nan into another format, forcing the quiet bit
module nan_transform (
   input  wire [127:0] opnd,
   input  wire [1:0]   srcFmt,
   input  wire [1:0]   dstFmt,
   output reg  [127:0] result
);
   reg [111:0] frac;
   // left-align the fraction so upper bits map to upper bits
   always @* begin
      frac = 112'h0;
      case (srcFmt)
         `FMT_S: frac = {opnd[118:96], 89'h0};
         `FMT_D: frac = {opnd[115:64], 60'h0};
         default: frac = opnd[111:0];
      endcase
      frac[111] = 1'b1;
      result = 128'h0;
      // narrowing drops low bits, widening zero-fills them
      case (dstFmt)
         `FMT_S: result = {opnd[127], 8'hFF, frac[111:89], 96'h0};
         `FMT_D: result = {opnd[127], 11'h7FF, frac[111:60], 64'h0};
         default: result = {opnd[127], 15'h7FFF, frac};
      endcase
   end
endmodule // nan_transform

// ===== test/fp_nan_exception_policy_properties.sv
`include "fp_nan_regs.vh"
module fp_nan_exception_policy_properties (
   input wire         clk_sys,
   input wire         reset,
   input wire         clkEn,
   input wire         opValid,
   input wire [2:0]   opKind,
   input wire [1:0]   srcFmt,
   input wire [4:0]   rs2Num,
   input wire [2:0]   queueCount,
   input wire         resultValid,
   input wire         fccValid,
   input wire         floatTrap,
   input wire [2:0]   trapType,
   input wire [4:0]   trapCause
);
   timeunit 1ns;
   timeprecision 1ps;
   wire take;
   // an operation is taken only while the clock enable runs
   assign take = opValid && clkEn;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   a_trap_no_result: assert property (floatTrap |-> !resultValid && !fccValid)
      else $error("trap came with a write-back");
   a_misalign_trap: assert property (
      take && opKind == `OP_ARITH2 && ((srcFmt == `FMT_D && rs2Num[0]) || (srcFmt == `FMT_Q && rs2Num[1:0] != 2'h0))
      |=> floatTrap && trapType == `FTT_BADREG) else $error("misaligned operand not trapped");
   a_empty_queue: assert property (
      take && opKind == `OP_QREAD && queueCount == 3'h0 |=> floatTrap && trapType == `FTT_SEQ)
      else $error("empty queue read not trapped");
   a_ieee_onehot: assert property (floatTrap && trapType == `FTT_IEEE |-> $onehot(trapCause))
      else $error("arithmetic trap cause not one-hot");
   a_result_cause: assert property (resultValid |-> $past(take))
      else $error("result without a taken operation");
   a_trap_cause: assert property (floatTrap |-> $past(take))
      else $error("trap without a taken operation");
   a_fcc_cmp: assert property (fccValid |-> $past(take && (opKind == `OP_CMP || opKind == `OP_CMPE)))
      else $error("condition code written by a non-compare");
   a_cmp_answer: assert property (take && opKind == `OP_CMPE |=> fccValid || floatTrap)
      else $error("signaling compare gave no answer");
endmodule // fp_nan_exception_policy_properties

bind fp_nan_exception_policy fp_nan_exception_policy_properties props (
   .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .opValid(opValid), .opKind(opKind), .srcFmt(srcFmt),
   .rs2Num(rs2Num), .queueCount(queueCount), .resultValid(resultValid), .fccValid(fccValid),
   .floatTrap(floatTrap), .trapType(trapType), .trapCause(trapCause));

// ===== test/iu_trap_partner.sv
module iu_trap_partner #(
   parameter int DELAY = 8
) (
   input  wire  clk_sys,
   input  wire  reset,
   input  wire  floatTrap,
   output logic userHandlerEntry
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_q;
   // enter the user handler a fixed span after a trap; a new trap during the wait restarts the span
   always @(posedge clk_sys) begin
      if (reset) begin
         wait_q <= 8'h00;
         userHandlerEntry <= 1'b0;
      end else begin
         userHandlerEntry <= (wait_q == 8'h01);
         if (floatTrap)
            wait_q <= DELAY[7:0];
         else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
      end
   end
endmodule // iu_trap_partner

// ===== test/fp_nan_exception_policy_tb_top.sv
`include "fp_nan_regs.vh"
module fp_nan_exception_policy_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_sys = 1'b0, reset = 1'b1, clkEn = 1'b1, opValid = 1'b0, rs1Used = 1'b0;
   logic [2:0]   opKind = 3'h0, queueCount = 3'h0;
   logic [1:0]   srcFmt = 2'h0, dstFmt = 2'h0, cmpOrder = 2'h0;
   logic [4:0]   rs2Num = 5'h02, rdNum = 5'h04, arithExc = 5'h00;
   logic [127:0] rs1Val = 128'h0, rs2Val = 128'h0;
   logic         arithInvalid = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0, rdat, saved;
   wire  [31:0]  prdata;
   wire  [127:0] resultData;
   wire  [4:0]   resultReg, trapCause;
   wire  [2:0]   trapType;
   wire          resultValid, fccValid, floatTrap, pready, pslverr, irq, userHandlerEntry;
   logic         tr, rv, fv;
   logic [2:0]   tt;
   logic [4:0]   tc;
   logic [127:0] res;
   int           mismatches = 0, checks = 0;

   fp_nan_exception_policy dut (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .opValid(opValid),
      .opKind(opKind), .srcFmt(srcFmt), .dstFmt(dstFmt), .rs1Num(5'h00), .rs2Num(rs2Num), .rdNum(rdNum),
      .rs1Val(rs1Val), .rs2Val(rs2Val), .rs1Used(rs1Used), .cmpOrder(cmpOrder), .arithInvalid(arithInvalid),
      .arithExc(arithExc), .arithResult(128'h0), .queueCount(queueCount), .userHandlerEntry(userHandlerEntry),
      .resultValid(resultValid), .resultData(resultData), .resultReg(resultReg), .fccValid(fccValid),
      .floatTrap(floatTrap), .trapType(trapType), .trapCause(trapCause), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq));
   iu_trap_partner #(.DELAY(8)) partner (.clk_sys(clk_sys), .reset(reset), .floatTrap(floatTrap),
      .userHandlerEntry(userHandlerEntry));

   // clock and watchdog
   always #12.5 clk_sys = ~clk_sys;
   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      end_sim();
   end

   function automatic [63:0] S(input [31:0] x);
      S = {x, 32'h0};
   endfunction
   task automatic chk(input [159:0] got, input [159:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic note(input string n);
      $display("test %s done", n);
   endtask
   task automatic apb(input w, input [11:0] a, input [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one operation, capture its answer, then read the status word
   task automatic run(input [2:0] k, input [1:0] s, input [1:0] d, input u, input [63:0] a, input [63:0] b);
      @(posedge clk_sys);
      opValid <= 1'b1;
      opKind <= k;
      srcFmt <= s;
      dstFmt <= d;
      rs1Used <= u;
      rs1Val <= {a, 64'h0};
      rs2Val <= {b, 64'h0};
      @(posedge clk_sys);
      opValid <= 1'b0;
      #1;
      {tr, rv, fv, tt, tc, res} = {floatTrap, resultValid, fccValid, trapType, trapCause, resultData};
      apb(1'b0, `OFS_STATUS, 32'h0);
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      apb(1'b0, `OFS_TRAPMASK, 32'h0);
      chk(rdat[4:0], `RST_TRAPMASK);
      apb(1'b0, `OFS_IRQMASK, 32'h0);
      chk(rdat[2:0], `RST_IRQMASK);
      apb(1'b0, 12'h0FC, 32'h0);
      chk(rdat, 32'h0);
      note("reset values");
      run(`OP_CONV, `FMT_S, `FMT_D, 1'b0, S(32'h7FA00001), S(32'h7FA00001));
      chk({rv, res, rdat[4:0]}, {1'b1, 64'h7FFC000020000000, 64'h0, 5'h10});
      chk({pslverr, resultReg}, {1'b0, 5'h04});
      run(`OP_CONV, `FMT_D, `FMT_S, 1'b0, 64'h7FFABCDE00000000, 64'h7FFABCDE00000000);
      chk({rv, res, rdat[4:0]}, {1'b1, 32'h7FD5E6F0, 96'h0, 5'h00});
      note("conversion");
      cmpOrder <= `FCC_GT;
      run(`OP_CMP, `FMT_S, `FMT_S, 1'b1, S(32'h3F800000), S(32'h40000000));
      chk({fv, rdat[11:10], rdat[4:0]}, {1'b1, `FCC_GT, 5'h00});
      run(`OP_CMP, `FMT_S, `FMT_S, 1'b1, S(32'h7FC00000), S(32'h3F800000));
      chk({fv, rdat[11:10], rdat[4:0]}, {1'b1, `FCC_UN, 5'h00});
      run(`OP_CMPE, `FMT_S, `FMT_S, 1'b1, S(32'h7FC00000), S(32'h3F800000));
      chk({fv, rdat[11:10], rdat[4:0]}, {1'b1, `FCC_UN, 5'h10});
      run(`OP_CMP, `FMT_S, `FMT_S, 1'b1, S(32'h3F800000), S(32'h7F800001));
      chk({fv, rdat[11:10], rdat[4:0]}, {1'b1, `FCC_UN, 5'h10});
      note("compare");
      run(`OP_ARITH2, `FMT_S, `FMT_S, 1'b1, S(32'h7F800001), S(32'h7F800002));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'h7FC00002, 5'h10});
      run(`OP_ARITH2, `FMT_S, `FMT_S, 1'b1, S(32'h7FC00001), S(32'h7FC00002));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'h7FC00002, 5'h00});
      run(`OP_ARITH2, `FMT_S, `FMT_S, 1'b1, S(32'h7F800003), S(32'h3F800000));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'h7FC00003, 5'h10});
      run(`OP_ARITH1, `FMT_S, `FMT_S, 1'b0, S(32'h3F800000), S(32'h7FC00005));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'h7FC00005, 5'h00});
      run(`OP_ARITH1, `FMT_S, `FMT_S, 1'b0, S(32'h3F800000), S(32'hFF800005));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'hFFC00005, 5'h10});
      arithInvalid <= 1'b1;
      run(`OP_ARITH1, `FMT_S, `FMT_S, 1'b0, S(32'h3F800000), S(32'h40000000));
      chk({rv, res[127:96], rdat[4:0]}, {1'b1, 32'h7FFFFFFF, 5'h10});
      arithInvalid <= 1'b0;
      note("same format");
      rs2Num <= 5'h06;
      run(`OP_ARITH2, `FMT_Q, `FMT_Q, 1'b1, S(32'h3F800000), S(32'h3F800000));
      chk({tr, tt, rv}, {1'b1, `FTT_BADREG, 1'b0});
      rs2Num <= 5'h04;
      run(`OP_ARITH2, `FMT_Q, `FMT_Q, 1'b1, S(32'h3F800000), S(32'h3F800000));
      chk({tr, rv}, 2'h1);
      rdNum <= 5'h01;
      run(`OP_CONV, `FMT_S, `FMT_D, 1'b0, S(32'h3F800000), S(32'h3F800000));
      chk({tr, tt, rv}, {1'b1, `FTT_BADREG, 1'b0});
      rdNum <= 5'h04;
      apb(1'b0, `OFS_IRQSTAT, 32'h0);
      apb(1'b1, `OFS_IRQMASK, 32'h2);
      rs2Num <= 5'h05;
      run(`OP_ARITH2, `FMT_D, `FMT_D, 1'b1, S(32'h3F800000), S(32'h3F800000));
      chk({tr, tt, irq}, {1'b1, `FTT_BADREG, 1'b0});
      rs2Num <= 5'h02;
      run(`OP_QREAD, `FMT_S, `FMT_S, 1'b0, 64'h0, 64'h0);
      chk({tr, tt, irq}, {1'b1, `FTT_SEQ, 1'b1});
      apb(1'b0, `OFS_IRQSTAT, 32'h0);
      #1;
      chk({rdat[2:0], irq}, 4'hC);
      queueCount <= 3'h2;
      run(`OP_QREAD, `FMT_S, `FMT_S, 1'b0, 64'h0, 64'h0);
      chk(tr, 1'b0);
      queueCount <= 3'h0;
      note("traps and interrupt");
      queueCount <= 3'h2;
      apb(1'b1, `OFS_TRAPMASK, 32'h10);
      apb(1'b0, `OFS_STATUS, 32'h0);
      saved = rdat;
      run(`OP_CONV, `FMT_S, `FMT_D, 1'b0, S(32'h7FA00001), S(32'h7FA00001));
      chk({tr, tt, tc, rv}, {1'b1, `FTT_IEEE, 5'h10, 1'b0});
      chk({rdat[11:5], rdat[4:0], rdat[16:13]}, {saved[11:5], 5'h10, `FTT_IEEE, 1'b1});
      repeat (12) @(posedge clk_sys);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rdat[16:12], 5'h00);
      queueCount <= 3'h0;
      apb(1'b1, `OFS_TRAPMASK, 32'h1F);
      arithExc <= 5'h03;
      run(`OP_ARITH2, `FMT_S, `FMT_S, 1'b1, S(32'h3F800000), S(32'h40000000));
      chk({tr, tt, $onehot(tc), |(tc & 5'h03), rdat[4:0] == tc}, {1'b1, `FTT_IEEE, 3'h7});
      arithExc <= 5'h00;
      apb(1'b1, `OFS_TRAPMASK, 32'h0);
      clkEn <= 1'b0;
      run(`OP_ARITH2, `FMT_S, `FMT_S, 1'b1, S(32'h7F800001), S(32'h7F800002));
      chk({tr, rv}, 2'h0);
      clkEn <= 1'b1;
      note("masked trap and freeze");
      end_sim();
   end
endmodule // fp_nan_exception_policy_tb_top
